// File: core/fewp_pkg.sv
// constants for the erase, write-enable and sector protection command block
`default_nettype none
package fewp_pkg;
   // -------------------------------------------------------------------
   // opcodes
   // -------------------------------------------------------------------
   localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_CHIP_ERASE_A  = 8'h60;
   localparam logic [7:0] OP_CHIP_ERASE_B  = 8'hC7;
   localparam logic [7:0] OP_PROTECT       = 8'h36;
   localparam logic [7:0] OP_UNPROTECT     = 8'h39;

   // -------------------------------------------------------------------
   // geometry and framing
   // -------------------------------------------------------------------
   localparam int         SECTORS          = 16;
   localparam int         SECTOR_LSB       = 16;
   localparam int         ADDR_W           = 24;
   localparam logic [2:0] ADDR_BYTES_DONE  = 3'h4;
   localparam logic [SECTORS-1:0] PROT_RESET = 16'hFFFF;

   // -------------------------------------------------------------------
   // timing
   // -------------------------------------------------------------------
   localparam longint CLK_HZ             = 10_000_000;
   localparam longint CHIP_ERASE_TIME_MS = 10;
   localparam int     ERASE_CYCLES       = int'((CHIP_ERASE_TIME_MS * CLK_HZ) / 1000);

   // -------------------------------------------------------------------
   // engine states
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b01,
      ST_ERASE = 2'b10
   } fewp_state_e;
endpackage : fewp_pkg
`default_nettype wire

// File: core/fewp_cmd.sv
// serial command decoder for chip erase, write enable/disable and sector protection
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - opcodes 60h and C7h both mean chip erase; trailing bytes ignored
// - valid chip erase starts a self-timed whole-array erase at frame end
// - no erase if opcode incomplete or frame ends off a byte boundary
// - chip erase refused at frame end if any sector protected or locked down
// - rejected chip erase clears the write enable latch
// - busy shown during erase; latch cleared before the erase finishes
// - erase failure sets the erase/program error flag
// - erase, protect and unprotect not executed with the latch clear
// - opcode 06h sets the latch at frame end unless busy; trailing bytes ignored
// - opcode 04h clears the latch at frame end; trailing bytes ignored
// - incomplete or unaligned write-enable/disable leaves the latch unchanged
// - one protection bit per 64-Kbyte sector, all set after reset
// - protection bit one blocks erase of that sector, zero allows it
// - 36h plus three address bytes sets the sector bit, clears latch
// - 39h plus three address bytes clears the sector bit, clears latch
// - short address or unaligned end aborts, bit kept, latch cleared
// - with lock bit set protect/unprotect ignored, latch cleared
// - each byte shifted most significant bit first
module fewp_cmd #(
   parameter int P_ERASE_CYCLES = fewp_pkg::ERASE_CYCLES
) (
   input  wire logic                         i_clk,
   input  wire logic                         i_reset,
   input  wire logic                         i_cs_n,
   input  wire logic                         i_sck,
   input  wire logic                         i_si,
   input  wire logic                         i_protection_regs_lock,
   input  wire logic [fewp_pkg::SECTORS-1:0] i_sector_lockdown,
   input  wire logic                         i_erase_fail,
   output logic                              o_write_enable_latch,
   output logic                              o_busy,
   output logic                              o_erase_program_error_flag,
   output logic [fewp_pkg::SECTORS-1:0]      o_sector_protect,
   output logic                              o_erase_start
);

   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   function automatic logic is_chip_erase(input logic [7:0] op);
      is_chip_erase = (op == fewp_pkg::OP_CHIP_ERASE_A) ||
                      (op == fewp_pkg::OP_CHIP_ERASE_B);
   endfunction : is_chip_erase

   // -------------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------------
   logic [1:0] cs_sync_q;
   logic [1:0] sck_sync_q;
   logic [1:0] si_sync_q;
   logic       cs_prev_q;
   logic       sck_prev_q;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         cs_sync_q  <= 2'h3;
         sck_sync_q <= 2'h0;
         si_sync_q  <= 2'h0;
         cs_prev_q  <= 1'b1;
         sck_prev_q <= 1'b0;
      end else begin
         cs_sync_q  <= {cs_sync_q[0], i_cs_n};
         sck_sync_q <= {sck_sync_q[0], i_sck};
         si_sync_q  <= {si_sync_q[0], i_si};
         cs_prev_q  <= cs_sync_q[1];
         sck_prev_q <= sck_sync_q[1];
      end
   end

   logic cs_n_s;
   logic sck_rise;
   logic cs_rise;
   assign cs_n_s   = cs_sync_q[1];
   assign sck_rise = sck_sync_q[1] & ~sck_prev_q & ~cs_n_s;
   assign cs_rise  = cs_n_s & ~cs_prev_q;

   // -------------------------------------------------------------------
   // byte assembly
   // -------------------------------------------------------------------
   logic [6:0]                  shift_q;
   logic [2:0]                  bit_cnt_q;
   logic [2:0]                  byte_cnt_q;
   logic [7:0]                  opcode_q;
   logic [fewp_pkg::ADDR_W-1:0] addr_q;
   logic [7:0]                  byte_in;
   logic                        byte_done;

   assign byte_in   = {shift_q, si_sync_q[1]};
   assign byte_done = sck_rise && (bit_cnt_q == 3'h7);

   always_ff @(posedge i_clk) begin
      if (i_reset || cs_n_s) begin
         shift_q    <= 7'h00;
         bit_cnt_q  <= 3'h0;
         byte_cnt_q <= 3'h0;
      end else if (sck_rise) begin
         shift_q   <= byte_in[6:0];
         bit_cnt_q <= bit_cnt_q + 3'h1;
         if (byte_done && byte_cnt_q != fewp_pkg::ADDR_BYTES_DONE) begin
            byte_cnt_q <= byte_cnt_q + 3'h1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         opcode_q <= 8'h00;
         addr_q   <= 24'h000000;
      end else if (cs_n_s && !cs_rise) begin
         opcode_q <= 8'h00;
      end else if (byte_done) begin
         if (byte_cnt_q == 3'h0) begin
            opcode_q <= byte_in;
         end else if (byte_cnt_q != fewp_pkg::ADDR_BYTES_DONE) begin
            addr_q <= {addr_q[15:0], byte_in};
         end
      end
   end

   // -------------------------------------------------------------------
   // frame-end decode
   // -------------------------------------------------------------------
   logic       aligned;
   logic       got_op;
   logic       got_addr;
   logic       any_blocked;
   logic [3:0] sector_idx;
   logic       ev_we;
   logic       ev_wd;
   logic       ev_ce;
   logic       ev_prot_cmd;
   logic       ev_erase_go;
   logic       ev_prot_ok;
   fewp_pkg::fewp_state_e state_q;

   assign aligned     = (bit_cnt_q == 3'h0);
   assign got_op      = (byte_cnt_q != 3'h0);
   assign got_addr    = (byte_cnt_q == fewp_pkg::ADDR_BYTES_DONE);
   assign any_blocked = |(o_sector_protect | i_sector_lockdown);
   assign sector_idx  = addr_q[fewp_pkg::SECTOR_LSB +: 4];
   assign ev_we       = cs_rise && got_op && opcode_q == fewp_pkg::OP_WRITE_ENABLE &&
                        state_q == fewp_pkg::ST_IDLE;
   assign ev_wd       = cs_rise && got_op && opcode_q == fewp_pkg::OP_WRITE_DISABLE &&
                        state_q == fewp_pkg::ST_IDLE;
   assign ev_ce       = cs_rise && got_op && is_chip_erase(opcode_q) &&
                        o_write_enable_latch && state_q == fewp_pkg::ST_IDLE;
   assign ev_prot_cmd = cs_rise && got_op && o_write_enable_latch &&
                        state_q == fewp_pkg::ST_IDLE &&
                        (opcode_q == fewp_pkg::OP_PROTECT ||
                         opcode_q == fewp_pkg::OP_UNPROTECT);
   assign ev_erase_go = ev_ce && aligned && !any_blocked;
   assign ev_prot_ok  = ev_prot_cmd && got_addr && aligned &&
                        !i_protection_regs_lock;

   // -------------------------------------------------------------------
   // write enable latch
   // -------------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_write_enable_latch <= 1'b0;
      end else if (ev_we && aligned) begin
         o_write_enable_latch <= 1'b1;
      end else if (ev_wd && aligned) begin
         o_write_enable_latch <= 1'b0;
      end else if (ev_ce || ev_prot_cmd) begin
         o_write_enable_latch <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // sector protection bits
   // -------------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_sector_protect <= fewp_pkg::PROT_RESET;
      end else if (ev_prot_ok) begin
         o_sector_protect[sector_idx] <= (opcode_q == fewp_pkg::OP_PROTECT);
      end
   end

   // -------------------------------------------------------------------
   // erase engine
   // -------------------------------------------------------------------
   logic [31:0] erase_cnt_q;
   logic        fail_seen_q;
   logic        erase_end;

   assign erase_end = (state_q == fewp_pkg::ST_ERASE) &&
                      (erase_cnt_q == 32'(P_ERASE_CYCLES - 1));
   assign o_busy    = (state_q == fewp_pkg::ST_ERASE);

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_q <= fewp_pkg::ST_IDLE;
      end else begin
         case (state_q)
            fewp_pkg::ST_IDLE: begin
               if (ev_erase_go) begin
                  state_q <= fewp_pkg::ST_ERASE;
               end
            end
            fewp_pkg::ST_ERASE: begin
               if (erase_end) begin
                  state_q <= fewp_pkg::ST_IDLE;
               end
            end
            default: begin
               state_q <= fewp_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset || state_q != fewp_pkg::ST_ERASE) begin
         erase_cnt_q <= 32'h00000000;
      end else begin
         erase_cnt_q <= erase_cnt_q + 32'h00000001;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset || ev_erase_go) begin
         fail_seen_q <= 1'b0;
      end else if (o_busy && i_erase_fail) begin
         fail_seen_q <= 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_erase_program_error_flag <= 1'b0;
      end else if (erase_end) begin
         o_erase_program_error_flag <= fail_seen_q || i_erase_fail;
      end else if (ev_erase_go) begin
         o_erase_program_error_flag <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_erase_start <= 1'b0;
      end else begin
         o_erase_start <= ev_erase_go;
      end
   end

   // -------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------
   a_we_sets: assert property (@(posedge i_clk) disable iff (i_reset)
      ev_we && aligned |=> o_write_enable_latch)
      else $error("write enable did not set latch");
   a_wd_clears: assert property (@(posedge i_clk) disable iff (i_reset)
      ev_wd && aligned |=> !o_write_enable_latch)
      else $error("write disable did not clear latch");
   a_unaligned_wel: assert property (@(posedge i_clk) disable iff (i_reset)
      (ev_we || ev_wd) && !aligned |=> $stable(o_write_enable_latch))
      else $error("unaligned latch command changed latch");
   a_erase_runs: assert property (@(posedge i_clk) disable iff (i_reset)
      ev_erase_go |=> o_busy && o_erase_start && !o_write_enable_latch ##1 !o_erase_start)
      else $error("erase start sequence wrong");
   a_erase_refused: assert property (@(posedge i_clk) disable iff (i_reset)
      ev_ce && (any_blocked || !aligned) |=> !o_busy && !o_write_enable_latch)
      else $error("refused erase not handled");
   a_no_wel_exec: assert property (@(posedge i_clk) disable iff (i_reset)
      cs_rise && !o_write_enable_latch && !o_busy |=> $stable(o_sector_protect) && !o_busy)
      else $error("command executed without latch");
   a_prot_lock: assert property (@(posedge i_clk) disable iff (i_reset)
      ev_prot_cmd && i_protection_regs_lock |=>
         $stable(o_sector_protect) && !o_write_enable_latch)
      else $error("locked protection bits changed");
   a_prot_update: assert property (@(posedge i_clk) disable iff (i_reset)
      ev_prot_ok |=> o_sector_protect[$past(sector_idx)] == ($past(opcode_q) == 8'h36))
      else $error("protection bit not updated");
   a_prot_short: assert property (@(posedge i_clk) disable iff (i_reset)
      ev_prot_cmd && !(got_addr && aligned) |=>
         $stable(o_sector_protect) && !o_write_enable_latch)
      else $error("aborted protect changed state");
   a_error_flag: assert property (@(posedge i_clk) disable iff (i_reset)
      erase_end && fail_seen_q |=> o_erase_program_error_flag && !o_busy)
      else $error("erase error not flagged");

   c_erase: cover property (@(posedge i_clk) disable iff (i_reset) ev_erase_go ##1 o_busy);
   c_protect: cover property (@(posedge i_clk) disable iff (i_reset)
      ev_prot_ok && opcode_q == fewp_pkg::OP_PROTECT);
   c_unprotect: cover property (@(posedge i_clk) disable iff (i_reset)
      ev_prot_ok && opcode_q == fewp_pkg::OP_UNPROTECT);
   c_erase_end: cover property (@(posedge i_clk) disable iff (i_reset) erase_end);

endmodule : fewp_cmd
`default_nettype wire

// File: verification/fewp_host.sv
// serial host model driving chip select, serial clock and data in
`timescale 1ns/1ps
`default_nettype none
module fewp_host (
   input  wire logic i_clk,
   output var logic  o_cs_n,
   output var logic  o_sck,
   output var logic  o_si
);
   initial begin
      o_cs_n = 1'b1;
      o_sck  = 1'b0;
      o_si   = 1'b0;
   end

   // half of the 800 ns link period
   task automatic half();
      repeat (4) @(posedge i_clk);
      #1;
   endtask : half

   // -------------------------------------------------------------------
   // one frame of n bits taken from the top of d
   // -------------------------------------------------------------------
   task automatic frame(input logic [47:0] d, input int n);
      @(posedge i_clk);
      #1;
      o_cs_n = 1'b0;
      for (int b = 0; b < n; b++) begin
         o_si = d[47-b];
         half();
         o_sck = 1'b1;
         half();
         o_sck = 1'b0;
      end
      half();
      o_cs_n = 1'b1;
      o_si   = ~o_si;
      repeat (3) half();
   endtask : frame
endmodule : fewp_host
`default_nettype wire

// File: verification/fewp_cmd_tb.sv
// self-checking bench for the erase and protection command decoder
`timescale 1ns/1ps
`default_nettype none
module fewp_cmd_tb;
   logic        i_clk, i_reset, cs_n, sck, si, lock, fail, latch, busy, err, estart;
   logic [15:0] lockdown, prot, m_prot;
   logic        m_wel, m_err;
   logic [18:0] q[$];
   logic [31:0] rng;
   logic [7:0]  ops[6];
   int          error_cnt, tests_run, n_start, m_start;

   fewp_cmd #(.P_ERASE_CYCLES(20)) uut (.i_clk(i_clk), .i_reset(i_reset), .i_cs_n(cs_n),
      .i_sck(sck), .i_si(si), .i_protection_regs_lock(lock), .i_sector_lockdown(lockdown),
      .i_erase_fail(fail), .o_write_enable_latch(latch), .o_busy(busy),
      .o_erase_program_error_flag(err), .o_sector_protect(prot), .o_erase_start(estart));
   fewp_host host (.i_clk(i_clk), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));

   always #50 i_clk = ~i_clk;
   always @(posedge i_clk) if (estart) n_start <= n_start + 1;

   task automatic check(input string what, input logic [18:0] exp, input logic [18:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t  = v ^ (v << 13);
      t  = t ^ (t >> 17);
      xs = t ^ (t << 5);
   endfunction : xs

   // -------------------------------------------------------------------
   // reference model, note of expected state, then the frame itself
   // -------------------------------------------------------------------
   task automatic send(input logic [7:0] op, input logic [23:0] a, input int n);
      int   nb;
      logic ok, go;
      nb = n / 8;
      ok = (n % 8) == 0;
      go = 1'b0;
      if (nb > 0) begin
         if (op == ops[0] && ok) m_wel = 1'b1;
         if (op == ops[1] && ok) m_wel = 1'b0;
         if ((op == ops[2] || op == ops[3]) && m_wel) begin
            go = ok && m_prot == 16'h0000 && lockdown == 16'h0000;
            m_wel = 1'b0;
         end
         if ((op == ops[4] || op == ops[5]) && m_wel) begin
            m_wel = 1'b0;
            if (ok && nb >= 4 && !lock) m_prot[a[19:16]] = (op == ops[4]);
         end
      end
      q.push_back({go, go ? 1'b0 : m_err, m_wel, m_prot});
      if (go) m_err = fail;
      if (go) m_start++;
      rng = xs(rng);
      host.frame({op, a, rng[15:0]}, n);
      if (go) begin
         for (int w = 0; w < 40 && busy; w++) begin
            @(posedge i_clk);
            #1;
         end
         check("busy end", 19'h00000, {18'h00000, busy});
         if (busy) final_report();
      end
   endtask : send

   initial begin
      #1;
      forever begin
         @(posedge cs_n);
         repeat (6) @(posedge i_clk);
         #2;
         if (q.size() == 0) check("queue", 19'h00000, 19'h7FFFF);
         else check("state", q.pop_front(), {busy, err, latch, prot});
      end
   end

   initial begin
      repeat (100000) @(posedge i_clk);
      error_cnt++;
      $display("BAD watchdog expected end seen hang");
      final_report();
   end

   initial begin
      ops = '{fewp_pkg::OP_WRITE_ENABLE, fewp_pkg::OP_WRITE_DISABLE, fewp_pkg::OP_CHIP_ERASE_A,
              fewp_pkg::OP_CHIP_ERASE_B, fewp_pkg::OP_PROTECT, fewp_pkg::OP_UNPROTECT};
      {i_clk, lock, fail, lockdown, m_wel, m_err, n_start, m_start} = '0;
      {i_reset, m_prot, rng, error_cnt, tests_run} = {1'b1, 16'hFFFF, 32'h7A59D3D3, 64'h0};
      repeat (6) @(posedge i_clk);
      #1;
      i_reset = 1'b0;
      check("reset", 19'h0FFFF, {busy, err, latch, prot});
      send(ops[0], 24'h000000, 7);
      send(ops[0], 24'h000000, 8);
      send(ops[1], 24'h000000, 12);
      send(ops[1], 24'h000000, 16);
      send(ops[5], 24'h050000, 32);
      send(ops[0], 24'h000000, 8);
      send(ops[2], 24'h000000, 8);
      $display("test latch done");
      for (int s = 0; s < 16; s++) begin
         send(ops[0], 24'h000000, 8);
         send(ops[5], {rng[7:4], s[3:0], rng[23:8]}, 40);
      end
      send(ops[0], 24'h000000, 8);
      send(ops[4], 24'h030000, 24);
      send(ops[0], 24'h000000, 8);
      send(ops[4], 24'h030000, 35);
      lock = 1'b1;
      send(ops[0], 24'h000000, 8);
      send(ops[5], 24'h030000, 32);
      {lock, lockdown} = {1'b0, 16'h0100};
      send(ops[0], 24'h000000, 8);
      send(ops[2], 24'h000000, 8);
      lockdown = 16'h0000;
      send(ops[0], 24'h000000, 8);
      send(ops[3], 24'h000000, 13);
      fail = 1'b1;
      send(ops[0], 24'h000000, 8);
      send(ops[2], 24'h000000, 8);
      fail = 1'b0;
      send(ops[0], 24'h000000, 8);
      send(ops[3], 24'h000000, 24);
      $display("test protect and erase done");
      for (int i = 0; i < 60; i++) begin
         rng = xs(rng);
         lock = rng[9] & rng[10];
         fail = rng[11];
         lockdown = (rng[31:28] == 4'h0) ? (16'h0001 << rng[3:0]) : 16'h0000;
         send(ops[rng[14:12] % 6], rng[31:8], (rng[19:16] % 6 + 1) * 8 - (rng[20] ? 3 : 0));
      end
      for (int i = 0; i < 50 && q.size() > 0; i++) @(posedge i_clk);
      check("drain", 19'h00000, 19'(q.size()));
      check("starts", 19'(m_start), 19'(n_start));
      $display("test random done");
      final_report();
   end
endmodule : fewp_cmd_tb
`default_nettype wire
